// File: shared/boost_cfg_pkg.sv
// Constants for the boost and adaptive configuration register bank.
// Assumes an 8-bit register port behind the serial slave, one clock.
package boost_cfg_pkg;

	// ------------------------------------------------------------
	// Register addresses
	// ------------------------------------------------------------
	localparam logic [7:0] ADDR_DRIVE_LIMIT = 8'hA7;
	localparam logic [7:0] ADDR_CEILING_JUMP = 8'hA9;
	localparam logic [7:0] ADDR_SPREAD_HEADROOM = 8'hAA;

	// ------------------------------------------------------------
	// Reset values and writable-bit masks
	// ------------------------------------------------------------
	// Nonvolatile defaults are not known here; zero is a safe start
	localparam logic [7:0] RST_DRIVE_LIMIT = 8'h00;
	localparam logic [7:0] RST_CEILING_JUMP = 8'h00;
	localparam logic [7:0] RST_SPREAD_HEADROOM = 8'h00;
	// Bits 7:6 of the first register have no access and read as zero
	localparam logic [7:0] MASK_DRIVE_LIMIT = 8'h3F;
	localparam logic [7:0] MASK_CEILING_JUMP = 8'hFF;
	localparam logic [7:0] MASK_SPREAD_HEADROOM = 8'hFF;
	localparam logic [7:0] READ_UNMAPPED = 8'h00;

	// ------------------------------------------------------------
	// Field positions
	// ------------------------------------------------------------
	localparam int THIRD_DRV_BIT = 5;
	localparam int SECOND_DRV_BIT = 4;
	localparam int ILIM_LSB = 0;
	localparam int CEIL_LSB = 5;
	localparam int JUMP_EN_BIT = 4;
	localparam int JUMP_TH_LSB = 2;
	localparam int JUMP_V_LSB = 0;
	localparam int SPREAD_BIT = 7;
	localparam int ADAPTIVE_BIT = 3;
	localparam int HEADROOM_LSB = 0;

	// ------------------------------------------------------------
	// Decode tables
	// ------------------------------------------------------------
	// Current limit in mA: 900, 1200, 1500, 1800
	localparam logic [11:0] ILIM_NORMAL_MA [4] =
		'{12'h384, 12'h4B0, 12'h5DC, 12'h708};
	// Doubled option: 1600, 2100, 2600, not permitted
	localparam logic [11:0] ILIM_DOUBLE_MA [4] =
		'{12'h640, 12'h834, 12'hA28, 12'h000};
	localparam logic [1:0] ILIM_FORBIDDEN_CODE = 2'h3;
	// Ceiling in tenths of a volt; zero marks an undefined code
	localparam logic [8:0] CEIL_LOW_DV [8] =
		'{9'h000, 9'h000, 9'h000, 9'h000,
		9'h0D2, 9'h0FA, 9'h12C, 9'h154};
	localparam logic [8:0] CEIL_HIGH_DV [8] =
		'{9'h000, 9'h000, 9'h0D2, 9'h0FA,
		9'h12C, 9'h159, 9'h186, 9'h1AE};
	// Jump threshold in percent: 10, 30, 50, 70
	localparam logic [6:0] JUMP_PCT [4] =
		'{7'h0A, 7'h1E, 7'h32, 7'h46};
	// Jump voltage in mV: 500, 1000, 2000, 4000
	localparam logic [11:0] JUMP_MV [4] =
		'{12'h1F4, 12'h3E8, 12'h7D0, 12'hFA0};
	// Headroom above the fixed offset: 875 mV less 125 mV a code
	localparam logic [9:0] HEADROOM_BASE_MV = 10'h36B;
	localparam logic [9:0] HEADROOM_STEP_MV = 10'h07D;
	localparam logic [2:0] HEADROOM_LAST_CODE = 3'h6;

endpackage

// File: logic/cfg_reg8.sv
// One 8-bit configuration register with a writable-bit mask.
// Assumes the write strobe is already decoded for this address.
module cfg_reg8 #(
	parameter logic [7:0] RESET_VALUE = 8'h00,
	parameter logic [7:0] WRITE_MASK = 8'hFF
) (
	// Clock and reset
	input wire logic i_clk,
	input wire logic i_rstn,
	// Write side
	input wire logic i_we,
	input wire logic [7:0] i_wdata,
	// Stored value
	output logic [7:0] o_q
);

	logic [7:0] q_q;

	// Bits outside the mask never store, so they always read zero
	always_ff @(posedge i_clk) begin
		if (!i_rstn) begin
			q_q <= RESET_VALUE & WRITE_MASK;
		end else if (i_we) begin
			q_q <= i_wdata & WRITE_MASK;
		end
	end

	assign o_q = q_q;

endmodule

// File: logic/boost_adaptive_config_regs.sv
// Boost drive, ceiling, jump detect and headroom configuration bank.
// Assumes the serial slave presents decoded byte reads and writes
// synchronous to i_clk; range and doubling bits come from elsewhere.
//
// Summary of operation
// - Bits 5 and 4 each enable one extra boost driver stage.
// - Two-bit code picks one of four current limits, or one of three in the doubled set.
// - Three-bit code picks boost ceiling; table depends on range bit.
// - Jump enable watches PWM input; threshold 10/30/50/70 percent.
// - Jump voltage code picks 0.5, 1, 2 or 4 V.
// - Headroom is offset plus 875 mV, less 125 mV per code.
module boost_adaptive_config_regs (
	// Clock and reset
	input wire logic i_clk,
	input wire logic i_rstn,
	// Register port
	input wire logic [7:0] i_addr,
	input wire logic i_wr_en,
	input wire logic [7:0] i_wdata,
	input wire logic i_rd_en,
	output logic [7:0] o_rdata,
	output logic o_rd_valid,
	output logic o_rd_unmapped,
	// Option bits held in neighbouring registers
	input wire logic i_doubled_limit_option,
	input wire logic i_boost_voltage_range_bit,
	// Boost driver and current limit
	output logic o_third_driver_stage_enable,
	output logic o_second_driver_stage_enable,
	output logic [1:0] o_inductor_current_limit_code,
	output logic [11:0] o_current_limit_ma,
	output logic o_current_limit_forbidden,
	// Boost ceiling
	output logic [2:0] o_boost_ceiling_code,
	output logic [8:0] o_boost_ceiling_dv,
	output logic o_boost_ceiling_undefined,
	// Jump detection
	output logic o_jump_detect_enable,
	output logic [6:0] o_jump_threshold_pct,
	output logic [11:0] o_jump_voltage_mv,
	// Spread spectrum, adaptive boost, headroom
	output logic o_spread_spectrum_enable,
	output logic o_adaptive_boost_enable,
	output logic [9:0] o_headroom_above_offset_mv,
	output logic o_headroom_undefined
);

	// ------------------------------------------------------------
	// Address decode and storage
	// ------------------------------------------------------------
	logic hit_drive;
	logic hit_ceiling;
	logic hit_spread;
	logic [7:0] drive_limit_q;
	logic [7:0] ceiling_jump_q;
	logic [7:0] spread_headroom_q;

	assign hit_drive = (i_addr == boost_cfg_pkg::ADDR_DRIVE_LIMIT);
	assign hit_ceiling = (i_addr == boost_cfg_pkg::ADDR_CEILING_JUMP);
	assign hit_spread = (i_addr == boost_cfg_pkg::ADDR_SPREAD_HEADROOM);

	cfg_reg8 #(
		.RESET_VALUE(boost_cfg_pkg::RST_DRIVE_LIMIT),
		.WRITE_MASK(boost_cfg_pkg::MASK_DRIVE_LIMIT)
	) u_drive_limit (
		.i_clk(i_clk),
		.i_rstn(i_rstn),
		.i_we(i_wr_en && hit_drive),
		.i_wdata(i_wdata),
		.o_q(drive_limit_q)
	);

	cfg_reg8 #(
		.RESET_VALUE(boost_cfg_pkg::RST_CEILING_JUMP),
		.WRITE_MASK(boost_cfg_pkg::MASK_CEILING_JUMP)
	) u_ceiling_jump (
		.i_clk(i_clk),
		.i_rstn(i_rstn),
		.i_we(i_wr_en && hit_ceiling),
		.i_wdata(i_wdata),
		.o_q(ceiling_jump_q)
	);

	cfg_reg8 #(
		.RESET_VALUE(boost_cfg_pkg::RST_SPREAD_HEADROOM),
		.WRITE_MASK(boost_cfg_pkg::MASK_SPREAD_HEADROOM)
	) u_spread_headroom (
		.i_clk(i_clk),
		.i_rstn(i_rstn),
		.i_we(i_wr_en && hit_spread),
		.i_wdata(i_wdata),
		.o_q(spread_headroom_q)
	);

	// ------------------------------------------------------------
	// Read port
	// ------------------------------------------------------------
	logic [7:0] rdata_d;
	logic [7:0] rdata_q;
	logic rd_valid_q;
	logic rd_unmapped_q;

	always_comb begin
		rdata_d = boost_cfg_pkg::READ_UNMAPPED;
		if (hit_drive) begin
			rdata_d = drive_limit_q;
		end else if (hit_ceiling) begin
			rdata_d = ceiling_jump_q;
		end else if (hit_spread) begin
			rdata_d = spread_headroom_q;
		end
	end

	// A read in the same cycle as a write returns the old value
	always_ff @(posedge i_clk) begin
		if (!i_rstn) begin
			rdata_q <= 8'h00;
			rd_valid_q <= 1'b0;
			rd_unmapped_q <= 1'b0;
		end else begin
			rd_valid_q <= i_rd_en;
			rd_unmapped_q <= i_rd_en && !(hit_drive || hit_ceiling ||
				hit_spread);
			if (i_rd_en) begin
				rdata_q <= rdata_d;
			end
		end
	end

	assign o_rdata = rdata_q;
	assign o_rd_valid = rd_valid_q;
	assign o_rd_unmapped = rd_unmapped_q;

	// ------------------------------------------------------------
	// Field extraction
	// ------------------------------------------------------------
	logic [1:0] ilim_code;
	logic [2:0] ceil_code;
	logic [1:0] jump_th_code;
	logic [1:0] jump_v_code;
	logic [2:0] head_code;

	assign ilim_code = drive_limit_q[boost_cfg_pkg::ILIM_LSB +: 2];
	assign ceil_code = ceiling_jump_q[boost_cfg_pkg::CEIL_LSB +: 3];
	assign jump_th_code = ceiling_jump_q[boost_cfg_pkg::JUMP_TH_LSB +: 2];
	assign jump_v_code = ceiling_jump_q[boost_cfg_pkg::JUMP_V_LSB +: 2];
	assign head_code = spread_headroom_q[boost_cfg_pkg::HEADROOM_LSB +: 3];

	// ------------------------------------------------------------
	// Boost driver strength and current limit
	// ------------------------------------------------------------
	logic third_drv_q;
	logic second_drv_q;
	logic [1:0] ilim_code_q;
	logic [11:0] ilim_ma_q;
	logic ilim_forbidden_q;

	always_ff @(posedge i_clk) begin
		if (!i_rstn) begin
			third_drv_q <= 1'b0;
			second_drv_q <= 1'b0;
		end else begin
			third_drv_q <= drive_limit_q[boost_cfg_pkg::THIRD_DRV_BIT];
			second_drv_q <= drive_limit_q[boost_cfg_pkg::SECOND_DRV_BIT];
		end
	end

	// The forbidden combination is flagged, not blocked: the host owns it
	always_ff @(posedge i_clk) begin
		if (!i_rstn) begin
			ilim_code_q <= 2'h0;
			ilim_ma_q <= 12'h000;
			ilim_forbidden_q <= 1'b0;
		end else begin
			ilim_code_q <= ilim_code;
			if (i_doubled_limit_option) begin
				ilim_ma_q <= boost_cfg_pkg::ILIM_DOUBLE_MA[ilim_code];
			end else begin
				ilim_ma_q <= boost_cfg_pkg::ILIM_NORMAL_MA[ilim_code];
			end
			ilim_forbidden_q <= i_doubled_limit_option &&
				(ilim_code == boost_cfg_pkg::ILIM_FORBIDDEN_CODE);
		end
	end

	assign o_third_driver_stage_enable = third_drv_q;
	assign o_second_driver_stage_enable = second_drv_q;
	assign o_inductor_current_limit_code = ilim_code_q;
	assign o_current_limit_ma = ilim_ma_q;
	assign o_current_limit_forbidden = ilim_forbidden_q;

	// ------------------------------------------------------------
	// Boost ceiling
	// ------------------------------------------------------------
	logic [2:0] ceil_code_q;
	logic [8:0] ceil_dv_d;
	logic [8:0] ceil_dv_q;
	logic ceil_undef_q;

	always_comb begin
		if (i_boost_voltage_range_bit) begin
			ceil_dv_d = boost_cfg_pkg::CEIL_HIGH_DV[ceil_code];
		end else begin
			ceil_dv_d = boost_cfg_pkg::CEIL_LOW_DV[ceil_code];
		end
	end

	// An undefined code reports zero volts so it cannot pass as valid
	always_ff @(posedge i_clk) begin
		if (!i_rstn) begin
			ceil_code_q <= 3'h0;
			ceil_dv_q <= 9'h000;
			ceil_undef_q <= 1'b0;
		end else begin
			ceil_code_q <= ceil_code;
			ceil_dv_q <= ceil_dv_d;
			ceil_undef_q <= (ceil_dv_d == 9'h000);
		end
	end

	assign o_boost_ceiling_code = ceil_code_q;
	assign o_boost_ceiling_dv = ceil_dv_q;
	assign o_boost_ceiling_undefined = ceil_undef_q;

	// ------------------------------------------------------------
	// Jump detection
	// ------------------------------------------------------------
	logic jump_en_q;
	logic [6:0] jump_pct_q;
	logic [11:0] jump_mv_q;

	always_ff @(posedge i_clk) begin
		if (!i_rstn) begin
			jump_en_q <= 1'b0;
			jump_pct_q <= 7'h00;
			jump_mv_q <= 12'h000;
		end else begin
			jump_en_q <= ceiling_jump_q[boost_cfg_pkg::JUMP_EN_BIT];
			jump_pct_q <= boost_cfg_pkg::JUMP_PCT[jump_th_code];
			jump_mv_q <= boost_cfg_pkg::JUMP_MV[jump_v_code];
		end
	end

	assign o_jump_detect_enable = jump_en_q;
	assign o_jump_threshold_pct = jump_pct_q;
	assign o_jump_voltage_mv = jump_mv_q;

	// ------------------------------------------------------------
	// Spread spectrum, adaptive boost, headroom
	// ------------------------------------------------------------
	logic spread_q;
	logic adaptive_q;
	logic [9:0] head_mv_q;
	logic head_undef_q;
	logic [9:0] head_drop;

	assign head_drop = 10'(head_code) * boost_cfg_pkg::HEADROOM_STEP_MV;

	always_ff @(posedge i_clk) begin
		if (!i_rstn) begin
			spread_q <= 1'b0;
			adaptive_q <= 1'b0;
		end else begin
			spread_q <= spread_headroom_q[boost_cfg_pkg::SPREAD_BIT];
			adaptive_q <= spread_headroom_q[boost_cfg_pkg::ADAPTIVE_BIT];
		end
	end

	// Code 111 has no level; it reports zero and raises the flag
	always_ff @(posedge i_clk) begin
		if (!i_rstn) begin
			head_mv_q <= 10'h000;
			head_undef_q <= 1'b0;
		end else if (head_code > boost_cfg_pkg::HEADROOM_LAST_CODE) begin
			head_mv_q <= 10'h000;
			head_undef_q <= 1'b1;
		end else begin
			head_mv_q <= boost_cfg_pkg::HEADROOM_BASE_MV - head_drop;
			head_undef_q <= 1'b0;
		end
	end

	assign o_spread_spectrum_enable = spread_q;
	assign o_adaptive_boost_enable = adaptive_q;
	assign o_headroom_above_offset_mv = head_mv_q;
	assign o_headroom_undefined = head_undef_q;

endmodule

// File: sim/host_model.sv
// Host model driving the bank's byte register port.
// Assumes requests change on the falling edge of the shared clock.
module host_model (
	// Clock
	input wire logic i_clk,
	// Requests
	output logic [7:0] o_addr,
	output logic o_wr_en,
	output logic [7:0] o_wdata,
	output logic o_rd_en,
	// Answers
	input wire logic [7:0] i_rdata,
	input wire logic i_rd_valid
);
	timeunit 1ns;
	timeprecision 1ns;
	initial begin
		o_addr = 8'h00;
		o_wr_en = 1'b0;
		o_wdata = 8'h00;
		o_rd_en = 1'b0;
	end
	// Sends bytes as given; illegal codes only when a test asks
	// Released lines flip so a stale value is never mistaken for live data
	task automatic wr(input logic [7:0] a, input logic [7:0] d);
		@(negedge i_clk);
		o_addr = a;
		o_wdata = d;
		o_wr_en = 1'b1;
		@(negedge i_clk);
		o_wr_en = 1'b0;
		o_addr = ~a;
		o_wdata = ~d;
	endtask
	task automatic rd(input logic [7:0] a, output logic [7:0] d,
		output logic v);
		@(negedge i_clk);
		o_addr = a;
		o_rd_en = 1'b1;
		@(negedge i_clk);
		o_rd_en = 1'b0;
		o_addr = ~a;
		d = i_rdata;
		v = i_rd_valid;
	endtask
endmodule

// File: sim/boost_cfg_checker.sv
// Checker for the boost configuration bank, bound to its top ports.
// Assumes one clock domain and synchronous active-low reset.
module boost_cfg_checker (
	// Clock and reset
	input wire logic i_clk,
	input wire logic i_rstn,
	// Register port
	input wire logic [7:0] i_addr,
	input wire logic i_wr_en,
	input wire logic [7:0] i_wdata,
	input wire logic i_rd_en,
	input wire logic [7:0] o_rdata,
	input wire logic o_rd_valid,
	input wire logic o_rd_unmapped,
	// Options
	input wire logic i_doubled_limit_option,
	input wire logic i_boost_voltage_range_bit,
	// Decoded outputs
	input wire logic o_third_driver_stage_enable,
	input wire logic o_second_driver_stage_enable,
	input wire logic [11:0] o_current_limit_ma,
	input wire logic o_current_limit_forbidden,
	input wire logic o_boost_ceiling_undefined,
	input wire logic o_jump_detect_enable,
	input wire logic [6:0] o_jump_threshold_pct,
	input wire logic [11:0] o_jump_voltage_mv,
	input wire logic o_spread_spectrum_enable,
	input wire logic o_adaptive_boost_enable,
	input wire logic [9:0] o_headroom_above_offset_mv
);
	default clocking @(posedge i_clk);
	endclocking
	default disable iff (!i_rstn);
	// Decoded outputs land one edge after the write edge, sampled on the second
	wire logic w7 = i_wr_en && i_addr == 8'hA7;
	wire logic w9 = i_wr_en && i_addr == 8'hA9;
	wire logic wa = i_wr_en && i_addr == 8'hAA;
	wire logic dbl = i_doubled_limit_option;
	wire logic rng = i_boost_voltage_range_bit;
	wire logic mapped = i_addr inside {8'hA7, 8'hA9, 8'hAA};
	rd_valid_a: assert property (i_rd_en |=> o_rd_valid)
		else $error("read gave no valid pulse");
	rd_pulse_a: assert property (!i_rd_en |=> !o_rd_valid)
		else $error("read valid without a read");
	unmapped_a: assert property (i_rd_en && !mapped |=>
		o_rd_unmapped && o_rdata == 8'h00) else $error("unmapped read");
	drive_stage_a: assert property (w7 |=> ##1
		{o_third_driver_stage_enable, o_second_driver_stage_enable} ==
		$past(i_wdata[5:4], 2)) else $error("driver stage enables wrong");
	limit_norm_a: assert property (w7 && !dbl ##1 !dbl |=>
		o_current_limit_ma == 12'h384 + 12'h12C * $past(i_wdata[1:0], 2))
		else $error("current limit wrong");
	limit_flag_a: assert property (w7 && dbl ##1 dbl |=>
		o_current_limit_forbidden == ($past(i_wdata[1:0], 2) == 2'h3))
		else $error("forbidden limit flag wrong");
	ceil_undef_a: assert property (w9 && rng ##1 rng |=>
		o_boost_ceiling_undefined == ($past(i_wdata[7:5], 2) < 3'h2))
		else $error("ceiling undefined flag wrong");
	jump_sel_a: assert property (w9 |=> ##1
		o_jump_detect_enable == $past(i_wdata[4], 2) &&
		o_jump_threshold_pct == 7'h0A + 7'h14 * $past(i_wdata[3:2], 2))
		else $error("jump enable or threshold wrong");
	jump_volt_a: assert property (w9 |=> ##1
		o_jump_voltage_mv == 12'h1F4 << $past(i_wdata[1:0], 2))
		else $error("jump voltage wrong");
	spread_adapt_a: assert property (wa |=> ##1
		{o_spread_spectrum_enable, o_adaptive_boost_enable} ==
		{$past(i_wdata[7], 2), $past(i_wdata[3], 2)})
		else $error("spread or adaptive enable wrong");
	headroom_a: assert property (wa && i_wdata[2:0] != 3'h7 |=> ##1
		o_headroom_above_offset_mv ==
		10'h36B - 10'h07D * $past(i_wdata[2:0], 2))
		else $error("headroom wrong");
	cover property (w7 && dbl);
	cover property (w9 && rng);
	cover property (i_rd_en && !mapped);
endmodule
bind boost_adaptive_config_regs boost_cfg_checker checker_i (.*);

// File: sim/tb_top.sv
// Testbench for the boost configuration bank.
// Assumes the host model drives the register port on falling edges.
`define CHK(a, e) begin num_checks++; if ((a) !== (e)) begin error_cnt++; \
	$display("Error %0t: got %h exp %h", $time, a, e); end end
module tb_top;
	timeunit 1ns;
	timeprecision 1ns;
	logic i_clk = 1'b0;
	logic i_rstn = 1'b0;
	logic i_doubled_limit_option = 1'b0;
	logic i_boost_voltage_range_bit = 1'b0;
	logic [7:0] i_addr, i_wdata, o_rdata, v;
	logic i_wr_en, i_rd_en, o_rd_valid, o_rd_unmapped;
	logic o_third_driver_stage_enable, o_second_driver_stage_enable;
	logic [1:0] o_inductor_current_limit_code;
	logic [11:0] o_current_limit_ma, o_jump_voltage_mv;
	logic o_current_limit_forbidden, o_boost_ceiling_undefined;
	logic [2:0] o_boost_ceiling_code;
	logic [8:0] o_boost_ceiling_dv;
	logic o_jump_detect_enable, o_spread_spectrum_enable;
	logic [6:0] o_jump_threshold_pct;
	logic o_adaptive_boost_enable, o_headroom_undefined;
	logic [9:0] o_headroom_above_offset_mv;
	logic [9:0] exp_head;
	logic [8:0] ceil_lo [8] = '{9'h000, 9'h000, 9'h000, 9'h000,
		9'h0D2, 9'h0FA, 9'h12C, 9'h154};
	logic [8:0] ceil_hi [8] = '{9'h000, 9'h000, 9'h0D2, 9'h0FA,
		9'h12C, 9'h159, 9'h186, 9'h1AE};
	int error_cnt = 0;
	int num_checks = 0;
	int cyc = 0;
	always #20 i_clk = ~i_clk;
	boost_adaptive_config_regs dut (.*);
	host_model host (.i_clk(i_clk), .o_addr(i_addr), .o_wr_en(i_wr_en),
		.o_wdata(i_wdata), .o_rd_en(i_rd_en), .i_rdata(o_rdata),
		.i_rd_valid(o_rd_valid));
	task automatic end_of_test;
		$display("checks %0d mismatches %0d", num_checks, error_cnt);
		if (error_cnt == 0 && num_checks > 0)
			$display("ALL TESTS PASSED");
		else
			$display("TESTS FAILED");
		$finish;
	endtask
	task automatic rdchk(input logic [7:0] a, input logic [7:0] e);
		logic [7:0] got;
		logic vld;
		host.rd(a, got, vld);
		`CHK(vld, 1'b1)
		`CHK(got, e)
	endtask
	// Hang guard: the tests need about 160 cycles
	always @(posedge i_clk) begin
		cyc++;
		if (cyc == 1000) begin
			error_cnt++;
			$display("Error %0t: timeout", $time);
			end_of_test();
		end
	end
	// ------------------------------------------------------------
	// Tests
	// ------------------------------------------------------------
	initial begin
		repeat (12) @(negedge i_clk);
		i_rstn = 1'b1;
		rdchk(8'hA7, 8'h00);
		rdchk(8'hAA, 8'h00);
		rdchk(8'hA8, 8'h00);
		`CHK(o_rd_unmapped, 1'b1)
		`CHK(o_current_limit_ma, 12'h384)
		$display("test reset done");
		host.wr(8'hA7, 8'hFF);
		@(negedge i_clk);
		rdchk(8'hA7, 8'h3F);
		`CHK(o_third_driver_stage_enable, 1'b1)
		`CHK(o_second_driver_stage_enable, 1'b1)
		`CHK(o_inductor_current_limit_code, 2'h3)
		`CHK(o_current_limit_ma, 12'h708)
		`CHK(o_current_limit_forbidden, 1'b0)
		// Code 3 with the doubled option is set on purpose to see the flag
		i_doubled_limit_option = 1'b1;
		@(negedge i_clk);
		`CHK(o_current_limit_forbidden, 1'b1)
		`CHK(o_current_limit_ma, 12'h000)
		// One stage bit per code, so a swap shows; bit 6 must not store
		for (int c = 0; c < 3; c++) begin
			host.wr(8'hA7, 8'(c) | (8'h10 << c));
			@(negedge i_clk);
			`CHK(o_current_limit_ma, 12'h640 + 12'h1F4 * 12'(c))
			`CHK(o_inductor_current_limit_code, 2'(c))
			`CHK(o_third_driver_stage_enable, (c == 1))
			`CHK(o_second_driver_stage_enable, (c == 0))
			`CHK(o_current_limit_forbidden, 1'b0)
		end
		i_doubled_limit_option = 1'b0;
		host.wr(8'hA8, 8'h55);
		rdchk(8'hA7, 8'h02);
		`CHK(o_current_limit_ma, 12'h5DC)
		$display("test drive_limit done");
		for (int r = 0; r < 2; r++) begin
			// Range clear also takes the undefined codes 2 and 3
			i_boost_voltage_range_bit = r[0];
			for (int c = 0; c < 8; c++) begin
				// Threshold and voltage get different codes, except when c is 0 or 7
				v = {c[2:0], c[0], c[1:0], c[2:1]};
				host.wr(8'hA9, v);
				@(negedge i_clk);
				`CHK(o_boost_ceiling_dv, r ? ceil_hi[c] : ceil_lo[c])
				`CHK(o_boost_ceiling_undefined, (r ? c < 2 : c < 4))
				`CHK(o_boost_ceiling_code, c[2:0])
				`CHK(o_jump_detect_enable, c[0])
				`CHK(o_jump_threshold_pct, 7'h0A + 7'h14 * 7'(c[1:0]))
				`CHK(o_jump_voltage_mv, 12'h1F4 << c[2:1])
				rdchk(8'hA9, v);
			end
		end
		$display("test ceiling_jump done");
		for (int h = 0; h < 8; h++) begin
			v = {h[0], h[2:0], h[1], h[2:0]};
			host.wr(8'hAA, v);
			@(negedge i_clk);
			`CHK(o_spread_spectrum_enable, h[0])
			`CHK(o_adaptive_boost_enable, h[1])
			exp_head = (h < 7) ? 10'h36B - 10'h07D * 10'(h) : 10'h000;
			`CHK(o_headroom_above_offset_mv, exp_head)
			`CHK(o_headroom_undefined, (h == 7))
			rdchk(8'hAA, v);
		end
		$display("test headroom done");
		// Reset in mid-run must bring the A9 and AA registers back to zero
		i_rstn = 1'b0;
		repeat (2) @(negedge i_clk);
		i_rstn = 1'b1;
		rdchk(8'hA9, 8'h00);
		rdchk(8'hAA, 8'h00);
		`CHK(o_headroom_above_offset_mv, 10'h36B)
		`CHK(o_spread_spectrum_enable, 1'b0)
		`CHK(o_jump_voltage_mv, 12'h1F4)
		$display("test mid reset done");
		end_of_test();
	end
endmodule
